/* File: verilog/reu_pkg.sv */
// Purpose: Shared constants and types for the reset and interrupt unit.
// Assumes: 32-bit classic Wishbone register bus, one word per register.
// Notes:   Vector addresses are two bytes each, at twice the vector number.
package reu_pkg;

  localparam int          NUM_IRQ_PINS   = 5;
  localparam int          NUM_WKP_PINS   = 8;
  localparam int          NUM_INT_SRC    = 16;
  localparam int          NUM_VEC        = 21;
  localparam int          RST_MIN_CYCLES = 10;

  // Register byte offsets
  localparam logic [7:0]  OFS_EDGE_SEL   = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN_1   = 8'h04;
  localparam logic [7:0]  OFS_IRQ_EN_2   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_REQ_1  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_REQ_2  = 8'h10;
  localparam logic [7:0]  OFS_WKP_REQ    = 8'h14;
  localparam logic [7:0]  OFS_CCR        = 8'h18;
  localparam logic [7:0]  OFS_STATUS     = 8'h1C;

  // Field positions
  localparam int          EN1_WKP_BIT    = 5;
  localparam int          CCR_I_BIT      = 7;
  localparam int          STAT_VEC_LSB   = 0;
  localparam int          STAT_FIRST_BIT = 8;
  localparam int          STAT_SERV_BIT  = 9;

  // Reset values
  localparam logic [4:0]  EDGE_SEL_RST   = 5'h00;
  localparam logic [2:0]  EDGE_RSVD_VAL  = 3'h7;
  localparam logic [5:0]  IRQ_EN_1_RST   = 6'h00;
  localparam logic [15:0] IRQ_EN_2_RST   = 16'h0000;
  localparam logic        CCR_I_RST      = 1'b1;

  // Vector numbers
  localparam logic [4:0]  VEC_RESET      = 5'h00;
  localparam logic [4:0]  VEC_IRQ0       = 5'h04;
  localparam logic [4:0]  VEC_WKP        = 5'h09;
  localparam logic [4:0]  VEC_SYNC_SER   = 5'h0A;
  localparam logic [4:0]  VEC_TMR_A      = 5'h0B;
  localparam logic [4:0]  VEC_TMR_B      = 5'h0C;
  localparam logic [4:0]  VEC_TMR_C      = 5'h0D;
  localparam logic [4:0]  VEC_TMR_FL     = 5'h0E;
  localparam logic [4:0]  VEC_TMR_FH     = 5'h0F;
  localparam logic [4:0]  VEC_ASYNC_SER  = 5'h12;
  localparam logic [4:0]  VEC_ADC        = 5'h13;
  localparam logic [4:0]  VEC_DIRECT     = 5'h14;

  // Internal source bit positions
  localparam int          SRC_SYNC_SER   = 0;
  localparam int          SRC_TMR_A      = 1;
  localparam int          SRC_TMR_B      = 2;
  localparam int          SRC_TMR_C_OVF  = 3;
  localparam int          SRC_TMR_C_UDF  = 4;
  localparam int          SRC_FL_CMP     = 5;
  localparam int          SRC_FL_OVF     = 6;
  localparam int          SRC_FH_CMP     = 7;
  localparam int          SRC_FH_OVF     = 8;
  localparam int          SRC_ASER_LO    = 9;
  localparam int          SRC_ASER_HI    = 14;
  localparam int          SRC_ADC        = 15;

  typedef struct packed {
    logic [4:0]  vector;
    logic [15:0] addr;
  } reu_exc_type;

  typedef enum logic [4:0] {
    ST_HALT    = 5'b00001,
    ST_INIT    = 5'b00010,
    ST_FETCH   = 5'b00100,
    ST_RUN     = 5'b01000,
    ST_SERVICE = 5'b10000
  } reu_state_type;

  function automatic logic [15:0] vec_addr(input logic [4:0] vec);
    vec_addr = {10'h000, vec, 1'b0};
  endfunction

endpackage

/* File: verilog/reu_pin_sync.sv */
// Purpose: Two-stage pin synchroniser with per-bit edge detection.
// Assumes: Pins idle high; rise_sel_i is on the local clock.
// Notes:   Edge pulse lasts one cycle.
`timescale 1ns/1ps
module reu_pin_sync
  import reu_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rise_sel_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] edge_o
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  // Chain keeps tracking the pins through reset, so a pin that already
  // sits low when reset ends is not mistaken for a fresh falling edge
  always_ff @(posedge clk_i)
  begin
    meta <= pin_i;
    sync <= meta;
    prev <= sync;
  end

  assign level_o = sync;
  // 1 picks rising, 0 picks falling; nothing is reported during reset
  assign edge_o  = rst_i ? '0 :
                   ((rise_sel_i & sync & ~prev) |
                    (~rise_sel_i & ~sync & prev));

endmodule

/* File: verilog/reu_prio_enc.sv */
// Purpose: Fixed-priority pick of the lowest pending vector number.
// Assumes: Bit n of pend_i is a request for vector n.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module reu_prio_enc
  import reu_pkg::*;
(
  input  wire logic [NUM_VEC-1:0] pend_i,
  output logic                    valid_o,
  output logic [4:0]              vector_o
);

  always_comb
  begin
    valid_o  = 1'b0;
    vector_o = VEC_RESET;
    // Scan downward so the lowest number wins
    for (int n = NUM_VEC - 1; n >= 0; n--)
    begin
      if (pend_i[n])
      begin
        valid_o  = 1'b1;
        vector_o = 5'(n);
      end
    end
  end

endmodule

/* File: verilog/reu_exc_unit.sv */
// Purpose: Reset sequencing and interrupt arbitration for a small CPU.
// Assumes: CPU pulses cpu_insn_done_i at every instruction boundary.
// Notes:   Registers on classic Wishbone, 32-bit words, ack one cycle on.
// Contract
// RL1: Interrupts start only at an instruction or exception boundary.
// RL2: Reset outranks all, processing begins as reset is released.
// RL3: Reset pin low halts everything until it returns high.
// RL4: Board holds reset pin low at least ten clocks when running.
// RL5: Reset processing initialises state, peripherals, sets mask bit.
// RL6: After init, program counter loads from reset vector at zero.
// RL7: Right after reset every interrupt is masked for one instruction.
// RL8: Thirteen external and sixteen internal sources are accepted.
// RL9: Simultaneous requests are served highest fixed priority first.
// RL10: Mask bit set still sets flags but blocks acceptance.
// RL11: Each request pin selects rising or falling edge independently.
// RL12: Priority falls with vector number; vector address twice number.
// RL13: Timer C overflow and underflow share vector thirteen.
// RL14: Lower 8-bit timer events share vector fourteen.
// RL15: Upper 8-bit timer events share vector fifteen.
// RL16: Six async serial events share vector eighteen.
// RL17: Edge select bit zero means falling, reset zero; one rising.
// RL18: Per-source enables gate interrupts and clear on reset.
// RL19: Software may only clear flags by writing zero.
// RL20: Masked flags stay pending and are taken once unmasked.
// RL21: Reset pin is synchronised before its release is detected.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module reu_exc_unit
  import reu_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    reset_n_pin_i,
  input  wire logic [NUM_IRQ_PINS-1:0] irq_n_pin_i,
  input  wire logic [NUM_WKP_PINS-1:0] wakeup_pin_i,
  input  wire logic [NUM_INT_SRC-1:0]  int_evt_i,
  input  wire logic                    sleep_xfer_req_i,
  input  wire logic                    cpu_insn_done_i,
  input  wire logic                    exc_ack_i,
  output logic                         exc_req_o,
  output reu_pkg::reu_exc_type         exc_info_o,
  output logic                         cpu_halt_o,
  output logic                         periph_rst_o,
  output logic                         cpu_imask_o,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o
);

  reu_state_type             state;
  reu_state_type             next_state;
  logic                      rst_meta;
  logic                      rst_sync;
  logic                      init_rst;
  logic [4:0]                edge_sel;
  logic [5:0]                irq_en_1;
  logic [15:0]               irq_en_2;
  logic [NUM_IRQ_PINS-1:0]   irq_flag;
  logic [NUM_WKP_PINS-1:0]   wkp_flag;
  logic [NUM_INT_SRC-1:0]    int_flag;
  logic                      ibit;
  logic                      first_mask;
  logic [NUM_IRQ_PINS-1:0]   irq_edge;
  logic [NUM_WKP_PINS-1:0]   wkp_edge;
  logic [NUM_IRQ_PINS-1:0]   irq_level;
  logic [NUM_WKP_PINS-1:0]   wkp_level;
  logic [NUM_VEC-1:0]        pend;
  logic                      arb_valid;
  logic [4:0]                arb_vec;
  logic                      take_irq;
  logic                      bus_req;
  logic                      wr_hit;
  logic [15:0]               wr_mask;
  logic [15:0]               clr_lo;
  logic [31:0]               rd_data;

  // Reset pin passes two flops before the sequencer looks at it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= reset_n_pin_i;                   // see RL21
      rst_sync <= rst_meta;                        // see RL21
    end
  end

  // Own registers clear while the unit is halted or initialising
  assign init_rst = rst_i | (state == ST_HALT) | (state == ST_INIT);

  reu_pin_sync #(
    .W(NUM_IRQ_PINS)
  ) u_irq_sync (
    .clk_i      (clk_i),
    .rst_i      (init_rst),
    .pin_i      (irq_n_pin_i),
    .rise_sel_i (edge_sel),                        // see RL11
    .level_o    (irq_level),
    .edge_o     (irq_edge)
  );

  reu_pin_sync #(
    .W(NUM_WKP_PINS)
  ) u_wkp_sync (
    .clk_i      (clk_i),
    .rst_i      (init_rst),
    .pin_i      (wakeup_pin_i),
    .rise_sel_i ({NUM_WKP_PINS{1'b0}}),
    .level_o    (wkp_level),
    .edge_o     (wkp_edge)
  );

  // Pending, enabled requests laid out by vector number
  always_comb
  begin
    pend = '0;
    for (int i = 0; i < NUM_IRQ_PINS; i++)
    begin
      pend[VEC_IRQ0 + 5'(i)] = irq_flag[i] & irq_en_1[i];   // see RL12
    end
    pend[VEC_WKP]       = (|wkp_flag) & irq_en_1[EN1_WKP_BIT];
    pend[VEC_SYNC_SER]  = int_flag[SRC_SYNC_SER] & irq_en_2[SRC_SYNC_SER];
    pend[VEC_TMR_A]     = int_flag[SRC_TMR_A] & irq_en_2[SRC_TMR_A];
    pend[VEC_TMR_B]     = int_flag[SRC_TMR_B] & irq_en_2[SRC_TMR_B];
    pend[VEC_TMR_C]     = |(int_flag[SRC_TMR_C_UDF:SRC_TMR_C_OVF] &
                            irq_en_2[SRC_TMR_C_UDF:SRC_TMR_C_OVF]); // see RL13
    pend[VEC_TMR_FL]    = |(int_flag[SRC_FL_OVF:SRC_FL_CMP] &
                            irq_en_2[SRC_FL_OVF:SRC_FL_CMP]);       // see RL14
    pend[VEC_TMR_FH]    = |(int_flag[SRC_FH_OVF:SRC_FH_CMP] &
                            irq_en_2[SRC_FH_OVF:SRC_FH_CMP]);       // see RL15
    pend[VEC_ASYNC_SER] = |(int_flag[SRC_ASER_HI:SRC_ASER_LO] &
                            irq_en_2[SRC_ASER_HI:SRC_ASER_LO]);     // see RL16
    pend[VEC_ADC]       = int_flag[SRC_ADC] & irq_en_2[SRC_ADC];    // see RL18
    pend[VEC_DIRECT]    = sleep_xfer_req_i;
  end

  reu_prio_enc u_prio (
    .pend_i   (pend),
    .valid_o  (arb_valid),                         // see RL9
    .vector_o (arb_vec)
  );

  // Acceptance only at a boundary, never during a service or first insn
  assign take_irq = (state == ST_RUN) & cpu_insn_done_i & arb_valid &
                    ~ibit & ~first_mask;           // see RL1, see RL10

  always_comb
  begin
    next_state = state;
    case (state)
      ST_HALT:    if (rst_sync) next_state = ST_INIT;     // see RL2
      ST_INIT:    next_state = ST_FETCH;
      ST_FETCH:   if (exc_ack_i) next_state = ST_RUN;
      ST_RUN:     if (take_irq) next_state = ST_SERVICE;
      ST_SERVICE: if (exc_ack_i) next_state = ST_RUN;
      default:    next_state = ST_HALT;
    endcase
    // Pin low overrides every state at once
    if (!rst_sync)
    begin
      next_state = ST_HALT;                        // see RL3
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_HALT;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Exception vector presented to the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state == ST_INIT)
    begin
      exc_info_o <= '{vector: VEC_RESET,
                      addr:   vec_addr(VEC_RESET)};       // see RL6
    end
    else if (take_irq)
    begin
      exc_info_o <= '{vector: arb_vec,
                      addr:   vec_addr(arb_vec)};         // see RL12
    end
  end

  assign exc_req_o    = (state == ST_FETCH) | (state == ST_SERVICE);
  assign cpu_halt_o   = (state == ST_HALT) | (state == ST_INIT); // see RL3
  assign periph_rst_o = cpu_halt_o;                              // see RL5
  assign cpu_imask_o  = ibit | first_mask;

  // First instruction after reset runs before anything can interrupt it
  always_ff @(posedge clk_i)
  begin
    if (init_rst)
    begin
      first_mask <= 1'b1;                          // see RL7
    end
    else if (state == ST_RUN && cpu_insn_done_i)
    begin
      first_mask <= 1'b0;
    end
  end

  // Bus decode; writes land on the edge that raises ack
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_hit  = bus_req & wb_we_i;
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign clr_lo  = wr_mask & ~wb_dat_i[15:0];

  always_ff @(posedge clk_i)
  begin
    if (init_rst)
    begin
      edge_sel <= EDGE_SEL_RST;                    // see RL17
      irq_en_1 <= IRQ_EN_1_RST;                    // see RL18
      irq_en_2 <= IRQ_EN_2_RST;
    end
    else if (wr_hit)
    begin
      if (wb_adr_i == OFS_EDGE_SEL && wb_sel_i[0])
      begin
        edge_sel <= wb_dat_i[4:0];
      end
      if (wb_adr_i == OFS_IRQ_EN_1 && wb_sel_i[0])
      begin
        irq_en_1 <= wb_dat_i[5:0];
      end
      if (wb_adr_i == OFS_IRQ_EN_2)
      begin
        irq_en_2 <= (irq_en_2 & ~wr_mask) | (wb_dat_i[15:0] & wr_mask);
      end
    end
  end

  // Flags: writing 0 clears, writing 1 does nothing, a new event wins
  always_ff @(posedge clk_i)
  begin
    if (init_rst)
    begin
      irq_flag <= '0;
      wkp_flag <= '0;
      int_flag <= '0;
    end
    else
    begin
      if (wr_hit && wb_adr_i == OFS_IRQ_REQ_1)
      begin
        irq_flag <= (irq_flag & ~clr_lo[4:0]) | irq_edge;     // see RL19
      end
      else
      begin
        irq_flag <= irq_flag | irq_edge;           // see RL10, see RL20
      end
      if (wr_hit && wb_adr_i == OFS_WKP_REQ)
      begin
        wkp_flag <= (wkp_flag & ~clr_lo[7:0]) | wkp_edge;     // see RL19
      end
      else
      begin
        wkp_flag <= wkp_flag | wkp_edge;           // see RL8
      end
      if (wr_hit && wb_adr_i == OFS_IRQ_REQ_2)
      begin
        int_flag <= (int_flag & ~clr_lo) | int_evt_i;         // see RL19
      end
      else
      begin
        int_flag <= int_flag | int_evt_i;          // see RL8
      end
    end
  end

  // Global mask: set by reset and by each accepted interrupt
  always_ff @(posedge clk_i)
  begin
    if (init_rst)
    begin
      ibit <= CCR_I_RST;                           // see RL5
    end
    else if (state == ST_SERVICE && exc_ack_i)
    begin
      ibit <= 1'b1;
    end
    else if (wr_hit && wb_adr_i == OFS_CCR && wb_sel_i[0])
    begin
      ibit <= wb_dat_i[CCR_I_BIT];                 // see RL20
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      OFS_EDGE_SEL:  rd_data[7:0]  = {EDGE_RSVD_VAL, edge_sel};
      OFS_IRQ_EN_1:  rd_data[5:0]  = irq_en_1;
      OFS_IRQ_EN_2:  rd_data[15:0] = irq_en_2;
      OFS_IRQ_REQ_1: rd_data[4:0]  = irq_flag;
      OFS_IRQ_REQ_2: rd_data[15:0] = int_flag;
      OFS_WKP_REQ:   rd_data[7:0]  = wkp_flag;
      OFS_CCR:       rd_data[CCR_I_BIT] = ibit;
      OFS_STATUS:
      begin
        rd_data[STAT_VEC_LSB +: 5] = exc_info_o.vector;
        rd_data[STAT_FIRST_BIT]    = first_mask;
        rd_data[STAT_SERV_BIT]     = (state == ST_SERVICE);
        rd_data[23:16]             = wkp_level;
        rd_data[28:24]             = irq_level;
      end
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // Bus answers even while halted so software never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

endmodule

/* File: verif/reu_exc_sva.sv */
// Purpose: Port-level assertions for the exception unit.
// Assumes: One clock domain, rst_i synchronous and active high.
// Notes:   Pin-reset bounds allow for the two-flop synchroniser.
`timescale 1ns/1ps
module reu_exc_sva
  import reu_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 reset_n_pin_i,
  input wire logic                 cpu_insn_done_i,
  input wire logic                 exc_ack_i,
  input wire logic                 exc_req_o,
  input wire reu_pkg::reu_exc_type exc_info_o,
  input wire logic                 cpu_halt_o,
  input wire logic                 periph_rst_o,
  input wire logic                 cpu_imask_o,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pin_low;
    !reset_n_pin_i [*3];
  endsequence
  // Pin high long enough for the sync path and the init cycle
  sequence s_pin_back;
    cpu_halt_o ##0 reset_n_pin_i [*5];
  endsequence
  // A new request that does not come from the reset fetch
  sequence s_new_req;
    $rose(exc_req_o) ##0 !$past(cpu_halt_o);
  endsequence

  a_rst_pin_halt: assert property (
    s_pin_low |=> cpu_halt_o && periph_rst_o)
    else $error("pin reset did not halt");
  a_rst_release: assert property (s_pin_back |=> !cpu_halt_o)
    else $error("reset release not taken");
  a_reset_fetch: assert property ($fell(cpu_halt_o) |->
    exc_req_o && exc_info_o == '0 && cpu_imask_o)
    else $error("bad reset vector fetch");
  a_req_at_bound: assert property (
    s_new_req |-> $past(cpu_insn_done_i))
    else $error("request off instruction boundary");
  a_req_unmasked: assert property (
    s_new_req |-> !$past(cpu_imask_o))
    else $error("request taken while masked");
  a_req_hold: assert property (
    exc_req_o && !exc_ack_i && reset_n_pin_i |=>
    exc_req_o && $stable(exc_info_o))
    else $error("request not held");
  a_req_drop: assert property (exc_req_o && exc_ack_i |=>
    !exc_req_o && cpu_imask_o)
    else $error("request not closed by ack");
  a_vec_addr: assert property (exc_req_o |->
    exc_info_o.addr == {10'h000, exc_info_o.vector, 1'b0})
    else $error("vector address mismatch");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
endmodule

bind reu_exc_unit reu_exc_sva u_sva (
  .clk_i,
  .rst_i,
  .reset_n_pin_i,
  .cpu_insn_done_i,
  .exc_ack_i,
  .exc_req_o,
  .exc_info_o,
  .cpu_halt_o,
  .periph_rst_o,
  .cpu_imask_o,
  .wb_cyc_i,
  .wb_stb_i,
  .wb_ack_o
);

/* File: verif/reu_cpu_model.sv */
// Purpose: Behavioural CPU core facing the exception unit.
// Assumes: An instruction ends every fourth cycle when nothing waits.
// Notes:   Ack latency comes from the bench, zero means prompt.
`timescale 1ns/1ps
module reu_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       exc_req_i,
  input  wire logic       halt_i,
  input  wire logic [3:0] lat_i,
  output logic            insn_done_o,
  output logic            ack_o
);
  logic [3:0] wait_cnt;
  logic [1:0] phase;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || halt_i)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // No instruction retires while an exception is being presented
  always_ff @(posedge clk_i)
  begin
    insn_done_o <= !rst_i && !halt_i && !exc_req_i && phase == 2'h3;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || halt_i || !exc_req_i || ack_o)
    begin
      wait_cnt <= 4'h0;
      ack_o <= 1'b0;
    end
    else if (wait_cnt >= lat_i)
      ack_o <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the exception unit.
// Assumes: Enables are set once; flags are cleared only by software.
// Notes:   Random masks come from an LFSR with a fixed seed.
`timescale 1ns/1ps
module tb;
  import reu_pkg::*;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    pin_n = 1'b1;
  logic [NUM_IRQ_PINS-1:0] irq_n = 5'h1F;
  logic [NUM_WKP_PINS-1:0] wakeup_pin = 8'hFF;
  logic [NUM_INT_SRC-1:0]  evt = 16'h0000;
  logic                    slp = 1'b0;
  logic                    done;
  logic                    ack;
  logic                    req;
  reu_exc_type             info;
  logic                    halt;
  logic                    imask;
  logic                    cyc = 1'b0;
  logic                    stb = 1'b0;
  logic                    we = 1'b0;
  logic [7:0]              adr = 8'h00;
  logic [3:0]              sel = 4'h3;
  logic [31:0]             wdat = 32'h0;
  logic [31:0]             rdat;
  logic [31:0]             q;
  logic                    wack;
  logic [3:0]              lat = 4'h0;
  logic [31:0]             r = 32'hB327;
  logic [4:0]              pp = 5'h00;
  logic [7:0]              wk = 8'h00;
  logic [15:0]             ii = 16'h0000;
  int                      fails = 0;
  int                      check_count = 0;

  always #2 clk_i = ~clk_i;

  reu_exc_unit dut (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .reset_n_pin_i    (pin_n),
    .irq_n_pin_i      (irq_n),
    .wakeup_pin_i     (wakeup_pin),
    .int_evt_i        (evt),
    .sleep_xfer_req_i (slp),
    .cpu_insn_done_i  (done),
    .exc_ack_i        (ack),
    .exc_req_o        (req),
    .exc_info_o       (info),
    .cpu_halt_o       (halt),
    .periph_rst_o     (),
    .cpu_imask_o      (imask),
    .wb_cyc_i         (cyc),
    .wb_stb_i         (stb),
    .wb_we_i          (we),
    .wb_adr_i         (adr),
    .wb_sel_i         (sel),
    .wb_dat_i         (wdat),
    .wb_dat_o         (rdat),
    .wb_ack_o         (wack)
  );

  reu_cpu_model cpu (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .exc_req_i   (req),
    .halt_i      (halt),
    .lat_i       (lat),
    .insn_done_o (done),
    .ack_o       (ack)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Internal source bit to its shared vector number
  function automatic logic [4:0] vec_of(input int i);
    return 5'(i < 3 ? 10 + i : i < 9 ? 13 + (i - 3) / 2 : i < 15 ? 18 : 19);
  endfunction

  function automatic logic [20:0] pend();
    logic [20:0] p;
    p = 21'h0;
    p[8:4] = pp;
    p[9] = |wk;
    p[20] = slp;
    for (int i = 0; i < 16; i++)
      if (ii[i])
        p[vec_of(i)] = 1'b1;
    return p;
  endfunction

  function automatic logic [4:0] first_vec(input logic [20:0] p);
    for (int i = 0; i < 21; i++)
      if (p[i])
        return 5'(i);
    return 5'h00;
  endfunction

  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail_out();
    fails++;
    print_verdict();
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_exc(input reu_exc_type got, input reu_exc_type exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
      fail_out();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_reg(q, exp);
  endtask

  task automatic wait_req(input logic b);
    int n;
    n = 0;
    while (req !== b && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300)
      fail_out();
  endtask

  task automatic reset_checks();
    wait_req(1'b1);
    chk_exc(info, '0);
    chk_reg({31'h0, imask}, 32'h1);
    rd(OFS_EDGE_SEL, 32'hE0);
    rd(OFS_IRQ_EN_2, 32'h0);
    rd(OFS_CCR, 32'h80);
    rd(OFS_IRQ_REQ_1, 32'h0);
  endtask

  // Take every pending request in order, clearing each after service
  task automatic drain();
    logic [4:0] v;
    int n;
    n = 0;
    while (pend() != 21'h0 && n < 40)
    begin
      v = first_vec(pend());
      n++;
      wb(1'b1, OFS_CCR, 32'h0);
      wait_req(1'b1);
      chk_exc(info, {v, 10'h000, v, 1'b0});
      wait_req(1'b0);
      if (v < 9)
        pp[v - 4] = 1'b0;
      else if (v == 9)
        wk = 8'h00;
      else if (v == 20)
        slp <= 1'b0;
      else
        for (int i = 0; i < 16; i++)
          if (vec_of(i) == v)
            ii[i] = 1'b0;
      wb(1'b1, OFS_IRQ_REQ_1, {27'h0, pp});
      wb(1'b1, OFS_IRQ_REQ_2, {16'h0, ii});
      wb(1'b1, OFS_WKP_REQ, {24'h0, wk});
    end
    if (pend() != 21'h0)
      fail_out();
  endtask

  task automatic round();
    r = lfsr(r);
    lat <= r[27:24];
    wb(1'b1, OFS_EDGE_SEL, {27'h0, r[4:0]});
    irq_n <= ~r[4:0];
    repeat (4) @(posedge clk_i);
    wb(1'b1, OFS_IRQ_REQ_1, 32'h0);
    pp = r[9:5];
    wk = r[17:10];
    irq_n <= irq_n ^ pp;
    wakeup_pin <= ~wk;
    slp <= r[18];
    r = lfsr(r);
    ii = r[15:0];
    evt <= ii;
    @(posedge clk_i);
    evt <= 16'h0000;
    repeat (6) @(posedge clk_i);
    wakeup_pin <= 8'hFF;
    rd(OFS_IRQ_REQ_1, {27'h0, pp});
    rd(OFS_WKP_REQ, {24'h0, wk});
    wb(1'b1, OFS_IRQ_REQ_2, 32'hFFFF);
    rd(OFS_IRQ_REQ_2, {16'h0, ii});
    drain();
    rd(OFS_IRQ_REQ_2, 32'h0);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_checks();
    rd(8'h20, 32'h0);
    wb(1'b1, OFS_IRQ_EN_1, 32'h3F);
    wb(1'b1, OFS_IRQ_EN_2, 32'hFFFF);
    for (int k = 0; k < 12; k++)
      round();
    pin_n <= 1'b0;
    repeat (RST_MIN_CYCLES) @(posedge clk_i);
    chk_reg({31'h0, halt}, 32'h1);
    pin_n <= 1'b1;
    reset_checks();
    print_verdict();
  end
endmodule
